// ---- verilog/ctn_defs.vh ----
// Constants for the chiller telemetry node
`ifndef CTN_DEFS_VH
`define CTN_DEFS_VH
// Register byte offsets
`define CTN_OFS_RUN 8'h00
`define CTN_OFS_OPCFG 8'h04
`define CTN_OFS_ALM_HI 8'h08
`define CTN_OFS_ALM_LO 8'h0c
`define CTN_OFS_NODECFG 8'h10
`define CTN_OFS_HEARTBEAT 8'h14
`define CTN_OFS_TEMP_RPT 8'h18
`define CTN_OFS_STAT_RPT 8'h1c
`define CTN_OFS_IRQ_STAT 8'h20
`define CTN_OFS_IRQ_MASK 8'h24
`define CTN_OFS_SAMPLE 8'h28
// Field positions
`define CTN_OPCFG_SEL_BIT 16
`define CTN_TEMP_PROBE_BIT 16
`define CTN_IRQ_TEMP_BIT 0
`define CTN_IRQ_STAT_BIT 1
`define CTN_ST_HOST_FAIL 0
`define CTN_ST_HIGH_TEMP 1
`define CTN_ST_LOCAL 2
`define CTN_ST_LVL_WARN 3
`define CTN_ST_LVL_FAIL 4
`define CTN_ST_FLOW_FAIL 5
// Run command codes
`define CTN_RUN_STATE_OFF 8'h00
`define CTN_RUN_STATE_LOW 8'h01
`define CTN_RUN_STATE_ON 8'h04
// Temperature codes: 16-bit two's complement, 16'h8000 = -100 degC, 100 degC/32768 per lsb
`define CTN_SETPOINT_RST 16'h2000
`define CTN_DEADBAND 17'h00147
`define CTN_REFRESH_PERIODS 4'ha
`define CTN_MINPER_RST 16'h0000
// Timing
`define CTN_CLK_KHZ 20000
`define CTN_SAMPLE_MS 1000
`define CTN_PERIOD_UNIT_MS 1
`endif

// ---- verilog/ctn_node.v ----
// Chiller telemetry node with APB register access
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "ctn_defs.vh"
module ctn_node #(
   parameter SAMPLE_CYCLES = `CTN_SAMPLE_MS * `CTN_CLK_KHZ,
   parameter UNIT_CYCLES = `CTN_PERIOD_UNIT_MS * `CTN_CLK_KHZ,
   parameter CNT_W = 25
) (
   // Clock and reset
   input wire I_CLK_SYS,
   input wire I_RST_N,
   // APB slave
   input wire I_PSEL,
   input wire I_PENABLE,
   input wire I_PWRITE,
   input wire [7:0] I_PADDR,
   input wire [31:0] I_PWDATA,
   output reg [31:0] O_PRDATA,
   output reg O_PREADY,
   output reg O_PSLVERR,
   // Process temperature converter
   output reg O_ADC_START,
   input wire I_ADC_DONE,
   input wire [15:0] I_ADC_DATA,
   // Setpoint converter and selection
   output reg [15:0] O_DAC_DATA,
   output reg O_SP_ANALOG_SEL,
   // Probe relay, run relay
   input wire I_REMOTE_SW,
   output reg O_PROBE_REMOTE,
   output reg O_RUN,
   // Status panel and node address straps
   input wire [5:0] I_STATUS,
   input wire [7:0] I_NODE_ADDR,
   // Interrupt
   output reg O_IRQ
);

   localparam ST_IDLE = 2'b01;
   localparam ST_CONV = 2'b10;

   // Two-stage synchronisers for every pin input except the APB bus, which is used directly
   reg [31:0] sy1;
   reg [31:0] sy2;
   wire s_done;
   wire s_sw;
   wire [5:0] s_status;
   wire [15:0] s_adc;
   wire [7:0] s_addr;
   reg done_d;
   wire done_rise;

   // Control and status state
   reg [1:0] state;
   reg [CNT_W-1:0] smp_cnt;
   reg [CNT_W-1:0] unit_cnt;
   reg [15:0] per_units;
   reg [3:0] nper;
   reg [15:0] alm_hi;
   reg [15:0] alm_lo;
   reg [15:0] min_per;
   reg sel_pend;
   reg sel_pend_v;
   reg [16:0] temp_rpt;
   reg [15:0] sample;
   reg [5:0] stat_rpt;
   reg [5:0] st_poll;
   reg local_err;
   wire [1:0] irq_st;
   wire [1:0] irq_evt;
   reg [1:0] irq_mask;

   // Bus decode
   wire setup;
   wire wr_en;
   wire local_mode;
   wire is_ctrl_cmd;
   reg [31:0] rd_data;
   reg rd_err;

   // Report decision
   reg [16:0] diff;
   reg [16:0] adiff;
   reg temp_send;
   reg stat_send;
   reg status_chg;
   wire smp_tick;
   wire unit_tick;
   wire period_done;

   function [5:0] err_code;
      input [5:0] st;
      input lerr;
      begin
         err_code = {lerr, st[`CTN_ST_FLOW_FAIL], st[`CTN_ST_LVL_FAIL],
            st[`CTN_ST_LVL_WARN], st[`CTN_ST_HIGH_TEMP], st[`CTN_ST_HOST_FAIL]};
      end
   endfunction

   assign s_done = sy2[31];
   assign s_sw = sy2[30];
   assign s_status = sy2[29:24];
   assign s_adc = sy2[23:8];
   assign s_addr = sy2[7:0];
   assign done_rise = s_done & ~done_d;

   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sy1 <= 32'h00000000;
         sy2 <= 32'h00000000;
         done_d <= 1'b0;
      end else begin
         sy1 <= {I_ADC_DONE, I_REMOTE_SW, I_STATUS, I_ADC_DATA, I_NODE_ADDR};
         sy2 <= sy1;
         done_d <= s_done;
      end
   end

   assign setup = I_PSEL & ~I_PENABLE;
   assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
   assign local_mode = s_status[`CTN_ST_LOCAL];
   assign is_ctrl_cmd = (I_PADDR == `CTN_OFS_RUN) || (I_PADDR == `CTN_OFS_OPCFG) ||
      (I_PADDR == `CTN_OFS_ALM_HI) || (I_PADDR == `CTN_OFS_ALM_LO);

   always @* begin
      rd_data = 32'h00000000;
      rd_err = 1'b0;
      case (I_PADDR)
         `CTN_OFS_RUN: rd_data = {31'h00000000, O_RUN};
         `CTN_OFS_OPCFG: rd_data = {15'h0000, O_SP_ANALOG_SEL, O_DAC_DATA};
         `CTN_OFS_ALM_HI: rd_data = {16'h0000, alm_hi};
         `CTN_OFS_ALM_LO: rd_data = {16'h0000, alm_lo};
         `CTN_OFS_NODECFG: rd_data = {16'h0000, min_per};
         `CTN_OFS_HEARTBEAT: rd_data = {24'h000000, s_addr};
         `CTN_OFS_TEMP_RPT: rd_data = {15'h0000, temp_rpt};
         `CTN_OFS_STAT_RPT: rd_data = {26'h0000000, stat_rpt};
         `CTN_OFS_IRQ_STAT: rd_data = {30'h00000000, irq_st};
         `CTN_OFS_IRQ_MASK: rd_data = {30'h00000000, irq_mask};
         `CTN_OFS_SAMPLE: rd_data = {16'h0000, sample};
         default: rd_err = 1'b1;
      endcase
   end

   // No wait state: the answer is prepared in the setup cycle
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PREADY <= 1'b0;
         O_PRDATA <= 32'h00000000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= setup;
         O_PRDATA <= (setup & ~I_PWRITE) ? rd_data : 32'h00000000;
         O_PSLVERR <= setup & rd_err;
      end
   end

   assign smp_tick = (smp_cnt == SAMPLE_CYCLES - 1);
   assign unit_tick = (unit_cnt == UNIT_CYCLES - 1);
   assign period_done = (per_units >= min_per) && (nper != `CTN_REFRESH_PERIODS);

   always @* begin
      diff = {s_adc[15], s_adc} - {temp_rpt[15], temp_rpt[15:0]};
      adiff = diff[16] ? (17'h00000 - diff) : diff;
      // Forced refresh at limit
      // Refresh waits for the next sample: with periods shorter than a sample
      // it lands at the first sample after the limit, never between samples
      // Gate on one full period
      temp_send = (state == ST_CONV) && done_rise && (nper != 4'h0) &&
         ((adiff > `CTN_DEADBAND) || (nper == `CTN_REFRESH_PERIODS));
      status_chg = smp_tick && (state == ST_IDLE) && (s_status != st_poll);
      stat_send = status_chg ||
         (wr_en && (I_PADDR == `CTN_OFS_HEARTBEAT) && (I_PWDATA[7:0] == s_addr)) ||
         (wr_en && is_ctrl_cmd && local_mode);
   end

   // Sampling sequencer and report timing
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state <= ST_IDLE;
         smp_cnt <= {CNT_W{1'b0}};
         unit_cnt <= {CNT_W{1'b0}};
         per_units <= 16'h0000;
         nper <= `CTN_REFRESH_PERIODS;
         O_ADC_START <= 1'b0;
         sample <= 16'h0000;
         temp_rpt <= 17'h00000;
         st_poll <= 6'h00;
      end else begin
         O_ADC_START <= 1'b0;
         smp_cnt <= smp_tick ? {CNT_W{1'b0}} : smp_cnt + 1'b1;
         unit_cnt <= unit_tick ? {CNT_W{1'b0}} : unit_cnt + 1'b1;
         if (period_done) begin
            per_units <= 16'h0000;
            nper <= nper + 4'h1;
         end else if (unit_tick && per_units != 16'hffff) begin
            per_units <= per_units + 16'h0001;
         end
         case (state)
            ST_IDLE: begin
               if (smp_tick) begin
                  st_poll <= s_status;
                  O_ADC_START <= 1'b1;
                  state <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (done_rise) begin
                  sample <= s_adc;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
         if (temp_send) begin
            temp_rpt <= {s_sw, s_adc};
            nper <= 4'h0;
            per_units <= 16'h0000;
            unit_cnt <= {CNT_W{1'b0}};
         end
      end
   end

   // Host commands and chiller outputs
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_DAC_DATA <= `CTN_SETPOINT_RST;
         O_SP_ANALOG_SEL <= 1'b0;
         sel_pend <= 1'b0;
         sel_pend_v <= 1'b0;
         O_RUN <= 1'b0;
         O_PROBE_REMOTE <= 1'b0;
         alm_hi <= 16'h0000;
         alm_lo <= 16'h0000;
         min_per <= `CTN_MINPER_RST;
         local_err <= 1'b0;
         stat_rpt <= 6'h00;
         irq_mask <= 2'b00;
      end else begin
         O_PROBE_REMOTE <= s_sw;
         sel_pend_v <= 1'b0;
         if (sel_pend_v) begin
            O_SP_ANALOG_SEL <= sel_pend;
         end
         // Local error holds until the chiller leaves local mode
         if (status_chg && !s_status[`CTN_ST_LOCAL]) begin
            local_err <= 1'b0;
         end
         if (wr_en) begin
            if (is_ctrl_cmd && local_mode) begin
               local_err <= 1'b1;
            end else begin
               case (I_PADDR)
                  `CTN_OFS_RUN: begin
                     if (I_PWDATA[7:0] == `CTN_RUN_STATE_OFF) begin
                        O_RUN <= 1'b0;
                     end else if (I_PWDATA[7:0] >= `CTN_RUN_STATE_LOW &&
                        I_PWDATA[7:0] <= `CTN_RUN_STATE_ON) begin
                        O_RUN <= 1'b1;
                     end
                  end
                  `CTN_OFS_OPCFG: begin
                     O_DAC_DATA <= I_PWDATA[15:0];
                     sel_pend <= I_PWDATA[`CTN_OPCFG_SEL_BIT];
                     sel_pend_v <= 1'b1;
                  end
                  `CTN_OFS_ALM_HI: alm_hi <= I_PWDATA[15:0];
                  `CTN_OFS_ALM_LO: alm_lo <= I_PWDATA[15:0];
                  `CTN_OFS_NODECFG: min_per <= I_PWDATA[15:0];
                  `CTN_OFS_IRQ_MASK: irq_mask <= I_PWDATA[1:0];
                  default: irq_mask <= irq_mask;
               endcase
            end
         end
         if (stat_send) begin
            stat_rpt <= err_code(status_chg ? s_status : st_poll,
               local_err | (wr_en && is_ctrl_cmd && local_mode));
         end
      end
   end

   // Event sources, one per sticky bit
   assign irq_evt[`CTN_IRQ_TEMP_BIT] = temp_send;
   assign irq_evt[`CTN_IRQ_STAT_BIT] = stat_send;

   // Write-one-clear of one event bit, shared by every sticky bit
   function clr_hit;
      input wr;
      input [7:0] addr;
      input [31:0] data;
      input integer idx;
      begin
         clr_hit = wr && (addr == `CTN_OFS_IRQ_STAT) && data[idx];
      end
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
         reg bit_q;
         assign irq_st[gi] = bit_q;
         // Sticky event; a new event wins over a clear in the same cycle
         always @(posedge I_CLK_SYS or negedge I_RST_N) begin
            if (!I_RST_N) begin
               bit_q <= 1'b0;
            end else if (irq_evt[gi]) begin
               bit_q <= 1'b1;
            end else if (clr_hit(wr_en, I_PADDR, I_PWDATA, gi)) begin
               bit_q <= 1'b0;
            end
         end
      end
   endgenerate

   // Level interrupt, one cycle behind the sticky bits
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= |(irq_st & irq_mask);
      end
   end

endmodule // ctn_node

// ---- sim/ctn_node_sva.sv ----
// Port checker for the chiller telemetry node
`timescale 1ns/1ps
module ctn_node_sva #(
   parameter SAMPLE_CYCLES = 200
) (
   // Clock, reset and bus
   input wire I_CLK_SYS, input wire I_RST_N, input wire I_PSEL, input wire I_PENABLE,
   input wire I_PWRITE, input wire [7:0] I_PADDR, input wire [31:0] I_PWDATA,
   input wire [31:0] O_PRDATA, input wire O_PREADY, input wire O_PSLVERR,
   // Chiller side
   input wire O_ADC_START, input wire [15:0] O_DAC_DATA, input wire O_SP_ANALOG_SEL,
   input wire I_REMOTE_SW, input wire O_PROBE_REMOTE, input wire O_RUN,
   input wire [5:0] I_STATUS, input wire O_IRQ
);
   localparam int SPM = SAMPLE_CYCLES - 1;
   wire wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
   wire wr_run = wr && I_PADDR == 8'h00;
   wire wr_op = wr && I_PADDR == 8'h04;
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   bus_answer_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
      else $error("ready not one cycle after setup");
   idle_data_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0 && !O_PSLVERR)
      else $error("data or error outside access");
   sample_period_a: assert property (O_ADC_START |=> !O_ADC_START ##SPM O_ADC_START)
      else $error("sample spacing wrong");
   dac_follow_a: assert property ((!I_STATUS[2])[*3] ##0 wr_op
      |=> O_DAC_DATA == $past(I_PWDATA[15:0])) else $error("setpoint not applied");
   sel_follow_a: assert property ((!I_STATUS[2])[*3] ##0 wr_op
      |=> ##1 O_SP_ANALOG_SEL == $past(I_PWDATA[16], 2)) else $error("select wrong");
   sel_order_a: assert property ($rose(O_SP_ANALOG_SEL) |-> $stable(O_DAC_DATA))
      else $error("select before setpoint");
   run_stop_a: assert property ((!I_STATUS[2])[*3] ##0 wr_run && I_PWDATA[7:0] == 8'h00
      |=> !O_RUN) else $error("stop not applied");
   run_start_a: assert property ((!I_STATUS[2])[*3] ##0 wr_run && I_PWDATA[7:0] != 8'h00
      && I_PWDATA[7:0] <= 8'h04 |=> O_RUN) else $error("start not applied");
   local_hold_a: assert property (I_STATUS[2][*3] ##0 wr_run |=> $stable(O_RUN))
      else $error("run changed in local mode");
   probe_follow_a: assert property ($stable(I_REMOTE_SW)[*8]
      |-> O_PROBE_REMOTE == I_REMOTE_SW) else $error("probe relay wrong");
   cover property (wr_op && I_PWDATA[16]);
   cover property (O_PSLVERR);
   cover property ($rose(O_IRQ));
endmodule // ctn_node_sva
bind ctn_node ctn_node_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) ctn_node_sva_i (
   .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_ADC_START(O_ADC_START),
   .O_DAC_DATA(O_DAC_DATA), .O_SP_ANALOG_SEL(O_SP_ANALOG_SEL), .I_REMOTE_SW(I_REMOTE_SW),
   .O_PROBE_REMOTE(O_PROBE_REMOTE), .O_RUN(O_RUN), .I_STATUS(I_STATUS), .O_IRQ(O_IRQ));

// ---- sim/ctn_adc_model.sv ----
// Process temperature converter model
`timescale 1ns/1ps
module ctn_adc_model (
   input wire i_clk,
   input wire i_start,
   input wire [15:0] i_code,
   input wire [3:0] i_lag,
   output reg o_done = 1'b0,
   output reg [15:0] o_data = 16'h0
);
   int cnt = 0;
   reg [15:0] held = 16'h0;
   // linear code held
   // Data holds from one cycle before done until one cycle after it; otherwise the lines scramble so a stale read cannot pass
   always @(posedge i_clk) begin
      held <= i_start ? i_code : held;
      cnt <= i_start ? 1 : (cnt != 0 && cnt < 40) ? cnt + 1 : 0;
      o_data <= (cnt >= i_lag && cnt != 0) ? held : ~o_data;
      o_done <= cnt > i_lag && cnt < 40;
   end
endmodule // ctn_adc_model

// ---- sim/tb.sv ----
// Self-checking bench for the chiller telemetry node
`timescale 1ns/1ps
module tb;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rsw = 0, e = 0;
   logic pready, pslverr, start, done, sel, probe, run, irq, er, h;
   logic [7:0] paddr = 8'h00, naddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h64f8dfbd;
   logic [15:0] adata, dac, code = 16'h0, a;
   logic [5:0] status = 6'h00;
   logic [3:0] lag = 4'h1;
   logic [7:0] cs [8] = '{8'h01, 8'h00, 8'h02, 8'h05, 8'h03, 8'h00, 8'h04, 8'hff};
   int err_count = 0, n_checks = 0, cyc = 0;
   // Short counts keep the run brief
   ctn_node #(.SAMPLE_CYCLES(200), .UNIT_CYCLES(10)) ctn_node_i (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_ADC_START(start), .I_ADC_DONE(done), .I_ADC_DATA(adata),
      .O_DAC_DATA(dac), .O_SP_ANALOG_SEL(sel), .I_REMOTE_SW(rsw), .O_PROBE_REMOTE(probe),
      .O_RUN(run), .I_STATUS(status), .I_NODE_ADDR(naddr), .O_IRQ(irq));
   ctn_adc_model ctn_adc_model_i (.i_clk(clk), .i_start(start), .i_code(code),
      .i_lag(lag), .o_done(done), .o_data(adata));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic rchk(input logic [7:0] ad, input logic [31:0] x);
      apb(0, ad, 32'h0);
      chk(rd, x);
   endtask
   // Two edges let the registered outputs settle
   task automatic w2(input logic [7:0] ad, input logic [31:0] d);
      apb(1, ad, d);
      repeat (2) @(posedge clk);
   endtask
   task automatic wirq(input int n, output logic f);
      for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clk);
      f = (irq === 1'b1);
   endtask
   task conclude;
      if (err_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      seed = lfsr(seed);
      rsw = seed[0];
      naddr = seed[15:8];
      lag = seed[7:4] | 4'h1;
      a = {3'b000, seed[28:16]};
      code = a;
      repeat (10) @(posedge clk);
      rst_n <= 1;
      chk(dac, 32'h2000);
      chk(irq, 0);
      w2(8'h24, 32'h1);
      w2(8'h10, 32'd50);
      wirq(300, h);
      chk(h, 1);
      rchk(8'h18, {15'h0, rsw, a});
      w2(8'h20, 32'h3);
      chk(irq, 0);
      code <= a + 16'd400;
      wirq(450, h);
      chk(h, 0);
      wirq(400, h);
      chk(h, 1);
      rchk(8'h18, {15'h0, rsw, a + 16'd400});
      w2(8'h20, 32'h3);
      code <= a + 16'd600;
      wirq(4400, h);
      chk(h, 0);
      wirq(1500, h);
      chk(h, 1);
      rchk(8'h18, {15'h0, rsw, a + 16'd600});
      rsw <= ~rsw;
      repeat (10) @(posedge clk);
      chk(probe, rsw);
      seed = lfsr(seed);
      w2(8'h04, {15'h0, 1'b1, seed[15:0]});
      chk(dac, seed[15:0]);
      chk(sel, 1);
      w2(8'h04, {15'h0, 1'b0, seed[31:16]});
      chk(dac, seed[31:16]);
      chk(sel, 0);
      for (int i = 0; i < 8; i++) begin
         apb(1, 8'h00, {24'h0, cs[i]});
         if (cs[i] == 8'h00) e = 0;
         else if (cs[i] <= 8'h04) e = 1;
         rchk(8'h00, {31'h0, e});
         chk(run, e);
      end
      apb(0, 8'h30, 32'h0);
      chk(er, 1);
      chk(rd, 0);
      w2(8'h20, 32'h3);
      status <= 6'h01;
      repeat (250) @(posedge clk);
      rchk(8'h1c, 32'h1);
      apb(0, 8'h20, 32'h0);
      chk(rd[1], 1);
      w2(8'h20, 32'h3);
      apb(1, 8'h14, {24'h0, naddr ^ 8'h01});
      apb(0, 8'h20, 32'h0);
      chk(rd[1], 0);
      apb(1, 8'h14, {24'h0, naddr});
      apb(0, 8'h20, 32'h0);
      chk(rd[1], 1);
      status <= 6'h05;
      repeat (250) @(posedge clk);
      apb(1, 8'h00, 32'h0);
      rchk(8'h00, 32'h1);
      rchk(8'h1c, 32'h21);
      w2(8'h24, 32'h2);
      chk(irq, 1);
      w2(8'h20, 32'h2);
      chk(irq, 0);
      conclude();
   end
endmodule // tb
